// ==== core/usb_cdc_uart_bridge.sv ====
// Serial bridge: frame buffers, byte FIFO and UART engine
`timescale 1ns/100ps

module bridge_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    // Pointer state
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   cnt;
    } fifo_st_t;

    fifo_st_t         st_ff;    // Registered state
    fifo_st_t         nxt_st;   // Next state
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign in_ready  = st_ff.cnt != (AW+1)'(DEPTH);
    assign out_valid = st_ff.cnt != '0;
    assign out_data  = mem[st_ff.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointer advance; full and empty come from the count
    always_comb
    begin
        nxt_st = st_ff;
        if (push)
        begin
            nxt_st.wr = st_ff.wr + 1'b1;
        end
        if (pop)
        begin
            nxt_st.rd = st_ff.rd + 1'b1;
        end
        nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage needs no reset
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[st_ff.wr] <= in_data;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end
endmodule

module usb_cdc_uart_bridge
    import bridge_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic        dtr,
    input  wire logic [19:0] cfg_baud_bps,
    input  wire logic [1:0]  cfg_parity,
    input  wire logic        cfg_two_stop,
    input  wire logic        cfg_write,
    input  wire logic        host_rx_valid,
    input  wire logic [7:0]  host_rx_data,
    input  wire logic        host_rx_last,
    output logic             host_rx_ready,
    output logic             host_tx_valid,
    output logic [7:0]       host_tx_data,
    output logic             host_tx_last,
    input  wire logic        host_tx_ready,
    input  wire logic        sof_tick,
    input  wire logic        ovr_valid,
    input  wire logic [7:0]  ovr_data,
    input  wire logic        ovr_last,
    output logic             ovr_ready,
    output logic             bridge_transmit_pin_o,
    output logic             bridge_transmit_pin_oe,
    input  wire logic        bridge_receive_pin,
    output logic             level_shift_en,
    output logic             rx_overrun
);

    // Whole block state
    typedef struct packed {
        logic                 session;      // DTR seen since reset
        logic                 configured;   // Rate written by host
        logic                 shift_en;     // Level shifters on
        logic                 hrx_ready;    // Outbound accept
        logic [1:0]           ob_wfr;       // Outbound fill frame
        logic [6:0]           ob_widx;
        logic [1:0]           ob_rfr;       // Outbound drain frame
        logic [6:0]           ob_ridx;
        logic [2:0]           ob_cnt;       // Committed frames
        logic [3:0][6:0]      ob_len;
        logic [3:0]           ovr_pos;      // Prefix chars matched
        logic                 ovr_bad;      // Not a command file
        logic [5:0]           ovr_sent;
        logic                 ovr_hold_v;   // Override byte held
        logic [7:0]           ovr_hold;
        logic                 ovr_rdy;
        phase_t               tx_ph;
        logic [15:0]          tx_cnt;
        logic [2:0]           tx_bit;
        logic [7:0]           tx_sh;
        logic                 tx_par;
        logic [1:0]           tx_parsel;
        logic                 tx_stop2;
        logic                 txd;
        logic                 txd_oe;
        phase_t               rx_ph;
        logic [15:0]          rx_cnt;
        logic [2:0]           rx_bit;
        logic [7:0]           rx_sh;
        logic [1:0]           rx_parsel;
        logic [2:0]           ib_wfr;       // Receive fill frame
        logic [6:0]           ib_widx;
        logic [2:0]           ib_rfr;       // Receive drain frame
        logic [6:0]           ib_ridx;
        logic [3:0]           ib_cnt;       // Frames in flight
        logic [7:0][6:0]      ib_len;
        logic [6:0]           sof_cnt;
        logic                 htx_valid;
        logic [7:0]           htx_data;
        logic                 htx_last;
        logic                 overrun;
    } bridge_st_t;

    bridge_st_t st_ff;                    // Registered state
    bridge_st_t nxt_st;                   // Next state

    logic [7:0] ob_mem [OB_FRAMES*FRAME_BYTES];  // Outbound frames
    logic [7:0] ib_mem [IB_FRAMES*FRAME_BYTES];  // Receive frames

    logic       ob_we;                    // Outbound write strobe
    logic       ib_we;                    // Receive write strobe
    logic       fifo_in_valid;
    logic       fifo_in_ready;
    logic [7:0] fifo_in_data;
    logic       fifo_out_valid;
    logic       fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic       ovr_active;               // Override owns transmit
    logic       drain_go;                 // Frame byte to FIFO
    logic [15:0] div;                     // Clocks per bit

    // Clamp the rate, then clocks per bit
    function automatic logic [15:0] baud_div(input logic [19:0] bps);
        logic [19:0] b;
        b = bps;
        if (b < BAUD_MIN_BPS)
        begin
            b = BAUD_MIN_BPS;             // [R3]
        end
        else if (b > BAUD_MAX_BPS)
        begin
            b = BAUD_MAX_BPS;             // [R3]
        end
        return 16'(CLK_HZ / int'(b));
    endfunction

    // Parity bit for a character, none gives the even bit
    function automatic logic par_bit(input logic [7:0] d,
                                     input logic [1:0] sel);
        return (sel == PAR_ODD) ? ~^d : ^d;  // [R6]
    endfunction

    // Override is active once the prefix matched or a byte waits
    assign ovr_active = (st_ff.ovr_pos == 4'(PREFIX_LEN))
                        || st_ff.ovr_hold_v;  // [R13]
    // Rate is read every bit, so a change lands mid-session
    assign div = (st_ff.configured || st_ff.session)
                 ? baud_div(cfg_baud_bps)       // [R3] [R4]
                 : baud_div(OVR_BAUD_BPS);      // [R15]
    // Normal frames pause while an override message goes out
    assign drain_go = !ovr_active && (st_ff.ob_cnt != 3'h0);
    assign fifo_in_valid = st_ff.ovr_hold_v || drain_go;
    assign fifo_in_data  = st_ff.ovr_hold_v ? st_ff.ovr_hold
                         : ob_mem[{st_ff.ob_rfr, st_ff.ob_ridx[5:0]}];
    assign fifo_out_ready = st_ff.tx_ph == PH_IDLE;
    assign ob_we = host_rx_valid && st_ff.hrx_ready;
    assign ib_we = (st_ff.rx_ph == PH_STOP) && (st_ff.rx_cnt == '0)
                   && bridge_receive_pin && dtr;

    // Byte FIFO between frame buffer and serialiser
    bridge_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // All next-state logic
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.overrun = 1'b0;

        // Session and configuration flags
        if (dtr)
        begin
            nxt_st.session  = 1'b1;       // [R10]
            nxt_st.shift_en = 1'b1;       // [R10] [R11]
        end
        if (cfg_write)
        begin
            nxt_st.configured = 1'b1;     // [R9]
        end
        // Pin stays released until DTR rises or an override becomes active
        nxt_st.txd_oe = st_ff.txd_oe || dtr || ovr_active;  // [R12]

        // Outbound fill, a frame closes at packet end or at 64 bytes
        if (ob_we)
        begin
            nxt_st.ob_widx = st_ff.ob_widx + 7'h1;
            if (host_rx_last || st_ff.ob_widx == 7'(FRAME_BYTES-1))
            begin
                nxt_st.ob_len[st_ff.ob_wfr] = st_ff.ob_widx + 7'h1;
                nxt_st.ob_wfr  = st_ff.ob_wfr + 2'h1;  // [R16]
                nxt_st.ob_widx = 7'h0;
            end
        end
        // Outbound drain into the FIFO, override first
        if (fifo_in_ready && st_ff.ovr_hold_v)
        begin
            nxt_st.ovr_hold_v = 1'b0;
        end
        else if (fifo_in_ready && drain_go)
        begin
            nxt_st.ob_ridx = st_ff.ob_ridx + 7'h1;     // [R1]
            if (st_ff.ob_ridx == st_ff.ob_len[st_ff.ob_rfr] - 7'h1)
            begin
                nxt_st.ob_ridx = 7'h0;
                nxt_st.ob_rfr  = st_ff.ob_rfr + 2'h1;
            end
        end
        nxt_st.ob_cnt = st_ff.ob_cnt
            + 3'(ob_we && (host_rx_last
                 || st_ff.ob_widx == 7'(FRAME_BYTES-1)))
            - 3'(fifo_in_ready && !st_ff.ovr_hold_v && drain_go
                 && st_ff.ob_ridx == st_ff.ob_len[st_ff.ob_rfr] - 7'h1);
        // Throttle at four frames; no new data without DTR
        nxt_st.hrx_ready = dtr
            && (nxt_st.ob_cnt != 3'(OB_FRAMES));      // [R17] [R11]

        // Override command parser
        if (ovr_valid && st_ff.ovr_rdy)
        begin
            if (st_ff.ovr_pos != 4'(PREFIX_LEN))
            begin
                if (!st_ff.ovr_bad
                    && ovr_data == OVR_PREFIX[st_ff.ovr_pos])
                begin
                    nxt_st.ovr_pos = st_ff.ovr_pos + 4'h1;  // [R13]
                end
                else
                begin
                    nxt_st.ovr_bad = 1'b1;  // Plain file, ignored
                end
            end
            else if (st_ff.ovr_sent != OVR_MAX_CHARS)
            begin
                nxt_st.ovr_hold   = ovr_data;
                nxt_st.ovr_hold_v = 1'b1;
                nxt_st.ovr_sent   = st_ff.ovr_sent + 6'h1;  // [R14]
            end
            if (ovr_last)
            begin
                nxt_st.ovr_pos  = 4'h0;
                nxt_st.ovr_bad  = 1'b0;
                nxt_st.ovr_sent = 6'h0;
            end
        end
        nxt_st.ovr_rdy = !nxt_st.ovr_hold_v;

        // Transmitter: start, data LSB first, parity, stops
        nxt_st.tx_cnt = st_ff.tx_cnt - 16'h1;
        case (st_ff.tx_ph)
            PH_IDLE:
            begin
                nxt_st.txd = 1'b1;
                if (fifo_out_valid)
                begin
                    nxt_st.tx_ph     = PH_START;
                    nxt_st.txd       = 1'b0;              // [R23]
                    nxt_st.tx_sh     = fifo_out_data;     // [R5]
                    nxt_st.tx_parsel = cfg_parity;
                    nxt_st.tx_par    = par_bit(fifo_out_data,
                                               cfg_parity);  // [R6]
                    nxt_st.tx_stop2  = cfg_two_stop;      // [R7]
                    nxt_st.tx_cnt    = div - 16'h1;
                end
            end
            PH_START:
            begin
                if (st_ff.tx_cnt == '0)
                begin
                    nxt_st.tx_ph  = PH_DATA;
                    nxt_st.txd    = st_ff.tx_sh[0];
                    nxt_st.tx_bit = 3'h0;
                    nxt_st.tx_cnt = div - 16'h1;          // [R4]
                end
            end
            PH_DATA:
            begin
                if (st_ff.tx_cnt == '0)
                begin
                    nxt_st.tx_cnt = div - 16'h1;
                    nxt_st.tx_sh  = {1'b0, st_ff.tx_sh[7:1]};
                    nxt_st.tx_bit = st_ff.tx_bit + 3'h1;
                    nxt_st.txd    = st_ff.tx_sh[1];
                    if (st_ff.tx_bit == 3'h7)
                    begin
                        if (st_ff.tx_parsel != PAR_NONE)
                        begin
                            nxt_st.tx_ph = PH_PAR;
                            nxt_st.txd   = st_ff.tx_par;   // [R23]
                        end
                        else
                        begin
                            nxt_st.tx_ph = PH_STOP;
                            nxt_st.txd   = 1'b1;
                        end
                    end
                end
            end
            PH_PAR:
            begin
                if (st_ff.tx_cnt == '0)
                begin
                    nxt_st.tx_ph  = PH_STOP;
                    nxt_st.txd    = 1'b1;                  // [R23]
                    nxt_st.tx_cnt = div - 16'h1;
                end
            end
            PH_STOP:
            begin
                if (st_ff.tx_cnt == '0)
                begin
                    nxt_st.tx_cnt = div - 16'h1;
                    if (st_ff.tx_stop2)
                    begin
                        nxt_st.tx_stop2 = 1'b0;            // [R7]
                    end
                    else
                    begin
                        nxt_st.tx_ph = PH_IDLE;
                    end
                end
            end
            default:
            begin
                nxt_st.tx_ph = PH_IDLE;
            end
        endcase

        // Receiver samples mid-bit; idle while DTR is low
        nxt_st.rx_cnt = st_ff.rx_cnt - 16'h1;
        case (st_ff.rx_ph)
            PH_IDLE:
            begin
                if (dtr && !bridge_receive_pin)            // [R10]
                begin
                    nxt_st.rx_ph     = PH_START;
                    nxt_st.rx_cnt    = {1'b0, div[15:1]};
                    nxt_st.rx_parsel = cfg_parity;
                end
            end
            PH_START:
            begin
                if (st_ff.rx_cnt == '0)
                begin
                    // A short low pulse is noise, not a start bit
                    nxt_st.rx_ph  = bridge_receive_pin ? PH_IDLE
                                                       : PH_DATA;
                    nxt_st.rx_bit = 3'h0;
                    nxt_st.rx_cnt = div - 16'h1;
                end
            end
            PH_DATA:
            begin
                if (st_ff.rx_cnt == '0)
                begin
                    nxt_st.rx_sh  = {bridge_receive_pin,
                                     st_ff.rx_sh[7:1]};
                    nxt_st.rx_bit = st_ff.rx_bit + 3'h1;
                    nxt_st.rx_cnt = div - 16'h1;
                    if (st_ff.rx_bit == 3'h7)
                    begin
                        nxt_st.rx_ph = (st_ff.rx_parsel != PAR_NONE)
                                       ? PH_PAR : PH_STOP;
                    end
                end
            end
            PH_PAR:
            begin
                if (st_ff.rx_cnt == '0)
                begin
                    nxt_st.rx_ph  = PH_STOP;
                    nxt_st.rx_cnt = div - 16'h1;
                end
            end
            PH_STOP:
            begin
                if (st_ff.rx_cnt == '0)
                begin
                    nxt_st.rx_ph = PH_IDLE;  // Bad stop drops byte
                end
            end
            default:
            begin
                nxt_st.rx_ph = PH_IDLE;
            end
        endcase

        // Receive frame packing and hand-off
        nxt_st.ib_cnt = st_ff.ib_cnt;
        if (sof_tick)
        begin
            nxt_st.sof_cnt = st_ff.sof_cnt + 7'h1;
        end
        if (ib_we)
        begin
            nxt_st.ib_widx = st_ff.ib_widx + 7'h1;         // [R2]
            if (st_ff.ib_widx == 7'(FRAME_BYTES-1))
            begin
                nxt_st.ib_widx = 7'h0;
                if (st_ff.ib_cnt != 4'(IB_FRAMES-1))       // [R20]
                begin
                    nxt_st.ib_len[st_ff.ib_wfr] = 7'(FRAME_BYTES);
                    nxt_st.ib_wfr = st_ff.ib_wfr + 3'h1;   // [R18]
                    nxt_st.ib_cnt = st_ff.ib_cnt + 4'h1;
                end
                else
                begin
                    nxt_st.overrun = 1'b1;  // Frame reused  [R21]
                end
            end
        end
        else if (st_ff.sof_cnt >= FLUSH_SOFS)
        begin
            // Flush waits for a free slot rather than lose data
            if (st_ff.ib_widx != 7'h0
                && st_ff.ib_cnt != 4'(IB_FRAMES-1))
            begin
                nxt_st.ib_len[st_ff.ib_wfr] = st_ff.ib_widx;
                nxt_st.ib_wfr  = st_ff.ib_wfr + 3'h1;      // [R19]
                nxt_st.ib_widx = 7'h0;
                nxt_st.ib_cnt  = st_ff.ib_cnt + 4'h1;
            end
            nxt_st.sof_cnt = 7'h0;
        end

        // Output register toward the host, one byte per handshake
        if (st_ff.htx_valid && host_tx_ready)
        begin
            nxt_st.htx_valid = 1'b0;
            nxt_st.ib_ridx   = st_ff.ib_ridx + 7'h1;
            if (st_ff.htx_last)
            begin
                nxt_st.ib_ridx = 7'h0;
                nxt_st.ib_rfr  = st_ff.ib_rfr + 3'h1;
                nxt_st.ib_cnt  = nxt_st.ib_cnt - 4'h1;
            end
        end
        else if (!st_ff.htx_valid && st_ff.ib_cnt != 4'h0)
        begin
            nxt_st.htx_valid = 1'b1;                       // [R2]
            nxt_st.htx_data  =
                ib_mem[{st_ff.ib_rfr, st_ff.ib_ridx[5:0]}];
            nxt_st.htx_last  = st_ff.ib_ridx
                               == st_ff.ib_len[st_ff.ib_rfr] - 7'h1;
        end
    end

    // Frame storage writes
    always_ff @(posedge ref_clk)
    begin
        if (ob_we)
        begin
            ob_mem[{st_ff.ob_wfr, st_ff.ob_widx[5:0]}] <= host_rx_data;
        end
        if (ib_we)
        begin
            ib_mem[{st_ff.ib_wfr, st_ff.ib_widx[5:0]}] <= st_ff.rx_sh;
        end
    end

    // State register; line idles high
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            st_ff     <= '0;
            st_ff.txd <= 1'b1;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // Outputs straight from state; no RTS or CTS exists  [R8]
    assign host_rx_ready          = st_ff.hrx_ready;
    assign host_tx_valid          = st_ff.htx_valid;
    assign host_tx_data           = st_ff.htx_data;
    assign host_tx_last           = st_ff.htx_last;
    assign ovr_ready              = st_ff.ovr_rdy;
    assign bridge_transmit_pin_o  = st_ff.txd;
    assign bridge_transmit_pin_oe = st_ff.txd_oe;
    assign level_shift_en         = st_ff.shift_en;
    assign rx_overrun             = st_ff.overrun;
endmodule

// ==== inc/bridge_pkg.sv ====
// Constants and types shared by the serial bridge design
// Behaviour
// [R1] Host characters go out on transmit pin
// [R2] Received target characters go to host
// [R3] Baud clamped to 1200 bps..500 kbps
// [R4] New baud applies during a running session
// [R5] Characters are always eight data bits
// [R6] Parity odd, even or none
// [R7] One or two stop bits
// [R8] No hardware handshake lines at all
// [R9] Config writable before session; data disabled
// [R10] DTR opens session, enables shifters, data
// [R11] DTR low: drain queued, stop receiving
// [R12] Transmit pin undriven until interface enabled
// [R13] Override prefix sends following characters
// [R14] Override sends at most fifty characters
// [R15] Override uses 9600 unless rate known
// [R16] Outbound data buffered as 64-byte frames
// [R17] At most four outbound frames; throttle
// [R18] Full receive frame handed to host
// [R19] Partial receive frames flushed every 100 ms
// [R20] At most eight receive frames in flight
// [R21] Overrun recycles last filled frame
// [R22] Host drains receive pipe to avoid overrun
// [R23] Start low, LSB first, parity, stops high
package bridge_pkg;

    // Clock rate
    localparam int CLK_PERIOD_NS = 40;
    localparam int CLK_HZ        = 1000000000 / CLK_PERIOD_NS;

    // Baud limits and override default, in bps
    localparam logic [19:0] BAUD_MIN_BPS = 20'd1200;
    localparam logic [19:0] BAUD_MAX_BPS = 20'd500000;
    localparam logic [19:0] OVR_BAUD_BPS = 20'd9600;

    // Frame geometry
    localparam int FRAME_BYTES = 64;
    localparam int OB_FRAMES   = 4;
    localparam int IB_FRAMES   = 8;
    localparam int FIFO_DEPTH  = 8;

    // Partial frame flush timing from start-of-frame tokens
    localparam int SOF_PERIOD_US = 1000;
    localparam int FLUSH_MS      = 100;
    localparam logic [6:0] FLUSH_SOFS =
        7'(FLUSH_MS * 1000 / SOF_PERIOD_US);

    // Override command prefix and message limit
    localparam int PREFIX_LEN = 14;
    localparam logic [0:PREFIX_LEN-1][7:0] OVR_PREFIX =
        "CMD:SEND_UART=";
    localparam logic [5:0] OVR_MAX_CHARS = 6'd50;

    // Parity selections
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ODD  = 2'h1;
    localparam logic [1:0] PAR_EVEN = 2'h2;

    // Serial character phases
    typedef enum logic [2:0] {
        PH_IDLE,
        PH_START,
        PH_DATA,
        PH_PAR,
        PH_STOP
    } phase_t;

endpackage

// ==== sim/bridge_port_checker.sv ====
// Port checker for the serial bridge
`timescale 1ns/100ps
module bridge_port_checker (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic dtr,
    input wire logic host_rx_ready,
    input wire logic host_tx_valid,
    input wire logic host_tx_ready,
    input wire logic bridge_transmit_pin_o,
    input wire logic bridge_transmit_pin_oe,
    input wire logic level_shift_en,
    input wire logic rx_overrun
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic [15:0] run_ff; // Cycles the pin level has held
    // Saturates: a long idle never wraps to a short bit
    always_ff @(posedge ref_clk or negedge arst_n)
        if (!arst_n)
            run_ff <= 16'h0;
        else if ($changed(bridge_transmit_pin_o))
            run_ff <= 16'h0;
        else if (run_ff != 16'hffff)
            run_ff <= run_ff + 16'h1;
    // Host holds back a byte the bridge offers
    sequence tx_stall;
        host_tx_valid && !host_tx_ready;
    endsequence
    ready_closed_a: assert property (!dtr [*3] |-> !host_rx_ready)
        else $error("ready while closed");
    ready_rise_a: assert property ($rose(host_rx_ready) |-> $past(dtr))
        else $error("ready rose while closed");
    oe_kept_a: assert property (
        bridge_transmit_pin_oe |=> bridge_transmit_pin_oe)
        else $error("pin enable dropped");
    shift_kept_a: assert property (level_shift_en |=> level_shift_en)
        else $error("shifters dropped");
    tx_hold_a: assert property (tx_stall |=> host_tx_valid)
        else $error("offer withdrawn");
    tx_gap_a: assert property (
        host_tx_valid && host_tx_ready |=> !host_tx_valid)
        else $error("valid after take");
    overrun_pulse_a: assert property (rx_overrun |=> !rx_overrun)
        else $error("overrun too long");
    bit_len_a: assert property (
        $changed(bridge_transmit_pin_o) |-> run_ff >= 16'd40)
        else $error("serial bit too short");
endmodule
bind usb_cdc_uart_bridge bridge_port_checker chk (.*);

// ==== sim/bridge_target_model.sv ====
// Target serial model on the bridge's far side
`timescale 1ns/100ps
module bridge_target_model #(
    parameter int DIV = 50 // Cycles per bit at 500 kbps
) (
    input  wire logic ref_clk,
    input  wire logic tx_pin,
    output logic      rx_pin
);
    logic [9:0] got;       // Data, then two bits after it
    int         n_got = 0; // Characters decoded
    initial rx_pin = 1'b1; // Target drives idle high
    // Start bit, then bits LSB first
    task send(input logic [9:0] bits);
        @(posedge ref_clk);
        rx_pin <= 1'b0;
        repeat (DIV) @(posedge ref_clk);
        for (int i = 0; i < 10; i++)
        begin
            rx_pin <= bits[i];
            repeat (DIV) @(posedge ref_clk);
        end
        rx_pin <= 1'b1;
    endtask
    // Mid-bit sampling from each start edge
    always @(negedge tx_pin)
    begin
        repeat (DIV / 2) @(posedge ref_clk);
        for (int i = 0; i < 10; i++)
        begin
            repeat (DIV) @(posedge ref_clk);
            got[i] = tx_pin;
        end
        n_got++;
    end
endmodule

// ==== sim/usb_cdc_uart_bridge_bench.sv ====
// Self-checking bench for the serial bridge
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
    n_mismatch++; $display("wrong value at %0t: %h", $time, a); end end
module usb_cdc_uart_bridge_bench;
    import bridge_pkg::*;
    logic        ref_clk = 1'b0, arst_n = 1'b0, dtr = 1'b0;
    logic        cfg_write = 1'b0, cfg_two_stop = 1'b0, sof_tick = 1'b0;
    logic        host_rx_valid = 1'b0, host_rx_last = 1'b1;
    logic        host_tx_ready = 1'b0, ovr_valid = 1'b0, ovr_last = 1'b0;
    logic [19:0] cfg_baud_bps = 20'h7a120; // 500000 bps
    logic [1:0]  cfg_parity = 2'h0;
    logic [7:0]  host_rx_data = 8'h00, host_tx_data, ovr_data;
    logic        host_rx_ready, host_tx_valid, host_tx_last, rx_overrun;
    logic        bridge_transmit_pin_o, bridge_transmit_pin_oe;
    logic        bridge_receive_pin, level_shift_en, ovr_ready;
    int          n_mismatch = 0, n_compared = 0;
    always #20 ref_clk = ~ref_clk; // 25 MHz
    usb_cdc_uart_bridge uut (.*);
    bridge_target_model tgt (.ref_clk(ref_clk),
        .tx_pin(bridge_transmit_pin_o), .rx_pin(bridge_receive_pin));
    task report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Nothing taken before a session
    task t_closed;
        cfg_write = 1'b1;
        host_rx_valid = 1'b1;
        @(negedge ref_clk);
        cfg_write = 1'b0;
        repeat (10) @(negedge ref_clk);
        `CHK(host_rx_ready, 1'b0)
        `CHK(bridge_transmit_pin_oe, 1'b0)
        host_rx_valid = 1'b0;
    endtask
    // Session opens
    task t_open;
        dtr = 1'b1;
        repeat (60) @(negedge ref_clk);
        `CHK(host_rx_ready, 1'b1)
        `CHK(level_shift_en, 1'b1)
    endtask
    // One byte out to the target
    task t_send(input logic [1:0] p, input logic [19:0] bps,
        input logic [7:0] b, input logic pb);
        int n0;
        n0 = tgt.n_got;
        cfg_parity = p;
        cfg_baud_bps = bps;
        host_rx_valid = 1'b1;
        host_rx_data = b;
        do @(posedge ref_clk); while (host_rx_ready !== 1'b1);
        @(negedge ref_clk);
        host_rx_valid = 1'b0;
        repeat (700) @(negedge ref_clk);
        `CHK(tgt.n_got, n0 + 1)
        `CHK(tgt.got, {1'b1, pb, b})
    endtask
    // One byte in, flushed by start-of-frame ticks
    task t_recv(input logic [7:0] b, input logic open);
        dtr = open;
        tgt.send({2'b11, b});
        repeat (220) @(negedge ref_clk) sof_tick = ~sof_tick;
        repeat (20) @(negedge ref_clk);
        `CHK(host_tx_valid, open)
        `CHK(host_rx_ready, open)
        `CHK(level_shift_en, 1'b1)
        if (open)
        begin
            `CHK({host_tx_last, host_tx_data}, {1'b1, b})
            host_tx_ready = 1'b1;
            @(negedge ref_clk);
            host_tx_ready = 1'b0;
            `CHK(host_tx_valid, 1'b0)
        end
    endtask
    // Override file
    task t_ovr(input logic [7:0] b);
        ovr_valid = 1'b1;
        for (int i = 0; i <= PREFIX_LEN; i++)
        begin
            ovr_data = i < PREFIX_LEN ? OVR_PREFIX[i] : b;
            ovr_last = i == PREFIX_LEN;
            @(posedge ref_clk iff ovr_ready);
            @(negedge ref_clk);
        end
        ovr_valid = 1'b0;
        repeat (700) @(negedge ref_clk);
        `CHK(tgt.got, {2'b11, b})
    endtask
    initial
    begin
        repeat (20) @(negedge ref_clk);
        arst_n = 1'b1;
        t_closed;
        t_open;
        t_send(PAR_EVEN, 20'h7a120, 8'ha5, ^8'ha5);
        t_send(PAR_ODD, 20'hdbba0, 8'h3c, ~^8'h3c);
        cfg_two_stop = 1'b1;
        t_send(PAR_NONE, 20'h7a120, 8'h81, 1'b1);
        t_ovr(8'h4d);
        t_recv(8'h5a, 1'b1);
        t_recv(8'hc3, 1'b0);
        report_and_stop;
    end
    // Run needs about 5000 cycles; allow four times that
    initial
    begin
        #(40 * 20000);
        n_mismatch++;
        report_and_stop;
    end
endmodule
